// ==== common/oau_regs.svh ====
// Constants for the operand address unit: fields, modes, offsets, steps
`ifndef OAU_REGS_SVH
`define OAU_REGS_SVH

// Instruction fields
`define OAU_SRC_HI 11
`define OAU_SRC_LO 6
`define OAU_DST_HI 2
`define OAU_DST_LO 0

// Addressing mode codes
`define OAU_M_REG 3'h0
`define OAU_M_REGDEF 3'h1
`define OAU_M_AINC 3'h2
`define OAU_M_AINCDEF 3'h3
`define OAU_M_ADEC 3'h4
`define OAU_M_ADECDEF 3'h5
`define OAU_M_IDX 3'h6
`define OAU_M_IDXDEF 3'h7

// Register indices and steps
`define OAU_PC_IDX 3'h7
`define OAU_SP_IDX 3'h6
`define OAU_WORD_STEP 16'h0002
`define OAU_BYTE_STEP 16'h0001
// Stack limit 400 octal
`define OAU_STACK_LIMIT 16'h0100
`define OAU_PS_T_BIT 4

// Register bus byte offsets
`define OAU_ADR_CTRL 8'h00
`define OAU_ADR_STATUS 8'h04
`define OAU_ADR_PS 8'h08
`define OAU_ADR_INSTR 8'h0c
`define OAU_ADR_OPND 8'h10
`define OAU_ADR_DEST 8'h14
`define OAU_ADR_REEVAL 8'h18
`define OAU_ADR_GPR_HI 3'h1

// Control bits
`define OAU_CTRL_RUN 0
`define OAU_CTRL_BYTE 1
`define OAU_CTRL_REEVAL 2
`define OAU_CTRL_RST 3'h0

// Status bits
`define OAU_ST_BND 0
`define OAU_ST_STK 1
`define OAU_ST_TRC 2
`define OAU_ST_IRQ 3
`define OAU_ST_BUSY 8
`define OAU_ST_RST 4'h0

`endif

// ==== common/oau_pkg.sv ====
// Types shared by the operand address unit
`default_nettype none
package oau_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_DECODE, ST_NW, ST_PTR, ST_OPND,
    ST_CHECK, ST_RVAL, ST_EXEC, ST_VEC
  } oau_state_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] rg;
  } oau_spec_t;

  typedef struct packed {
    logic irq;
    logic trc;
    logic stk;
    logic bnd;
  } oau_flags_t;
endpackage
`default_nettype wire

// ==== src/oau_step.sv ====
// Register step adder: plus or minus 1 or 2
`default_nettype none
`include "oau_regs.svh"
module oau_step #(
  parameter int W = 16
) (
  input wire logic [W-1:0] base,
  input wire logic byte_op,
  input wire logic force_word,
  input wire logic down,
  output logic [W-1:0] result
);
  logic [W-1:0] amt;

  if (W < 2) begin : g_chk
    $error("oau_step needs W of at least 2");
  end

  always_comb begin
    amt = (byte_op && !force_word) ? W'(`OAU_BYTE_STEP) :
      W'(`OAU_WORD_STEP);
    result = down ? base - amt : base + amt;
  end
endmodule
`default_nettype wire

// ==== src/oau_gpr.sv ====
// General register file with three addressed read ports, a fixed PC read port and one write port
`default_nettype none
module oau_gpr #(
  parameter int W = 16,
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [$clog2(N)-1:0] wa,
  input wire logic [W-1:0] wd,
  input wire logic [$clog2(N)-1:0] ra,
  input wire logic [$clog2(N)-1:0] rb,
  input wire logic [$clog2(N)-1:0] rc,
  output logic [W-1:0] da,
  output logic [W-1:0] db,
  output logic [W-1:0] dc,
  output logic [W-1:0] pc
);
  logic [W-1:0] mem_q [N];

  if (N != 8) begin : g_chk
    $error("oau_gpr needs exactly eight registers");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we) begin
      mem_q[wa] <= wd;
    end
  end

  assign da = mem_q[ra];
  assign db = mem_q[rb];
  assign dc = mem_q[rc];
  assign pc = mem_q[N-1];
endmodule
`default_nettype wire

// ==== src/oau_top.sv ====
// Operand address unit: fetch loop, operand modes, register bus slave
//
// Summary of operation
// - Source specifier bits 11:6 split mode/register
// - Destination operand is register from destination field
// - Next word read at PC, PC plus 2
// - Mode 0: register contents, no memory access
// - Mode 2 with PC: next word immediate
// - Auto-increment: use register address, then increment
// - Auto-decrement: decrement first, then use address
// - Indexed: next word plus register gives address
// - Indexed PC: next word plus updated PC
// - Mode 3 with PC: absolute address
// - Mode 3: pointer at register, increment, read
// - Mode 5: decrement, read pointer, read operand
// - Mode 7: pointer at next word plus register
// - Mode 7 with PC: PC-relative pointer
// - Check stack overflow after operand calculation
// - Re-evaluated immediate reads word at PC minus 2
// - Loop: fetch, PC plus 2, execute, trace
// - Trace bit traps after each instruction
// - Stack overflow when SP address below 400
// - Odd word address sets boundary error
// - Mode codes 0 to 7 as listed
//
// Implementation choices: the address map and the Wishbone register port.
`default_nettype none
`include "oau_regs.svh"
module oau_top #(
  parameter logic [15:0] TRAP_VEC = 16'h0010,
  parameter logic [15:0] IRQ_VEC = 16'h0020
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic MEM_REQ,
  output logic [15:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA,
  input wire logic IRQ_REQ,
  output logic IRQ_ACK,
  output logic OPND_VALID,
  output logic [15:0] OPND_DATA,
  output logic [15:0] DEST_DATA
);
  if (TRAP_VEC[0] || IRQ_VEC[0]) begin : g_chk
    $error("oau_top vectors must be even");
  end

  oau_pkg::oau_state_t state_q;
  oau_pkg::oau_spec_t spec;
  oau_pkg::oau_flags_t ev;
  logic [15:0] instr_q, addr_q, sp_addr_q, reeval_q, ps_q, opnd_q;
  logic [2:0] ctrl_q;
  logic [3:0] status_q;
  logic vec_irq_q, ack_q;
  logic [15:0] src_val, dst_val, sw_val, pc, stepped, pc_inc;
  logic gpr_we;
  logic [2:0] gpr_wa;
  logic [15:0] gpr_wd;
  logic mem_state, word_acc, odd_fault, mem_done, busy, ps_t;
  logic wb_req, wb_wr, sw_gpr;

  ////////////////////////////////////////////////////////////////////////
  // Decode and datapath helpers
  assign spec = instr_q[`OAU_SRC_HI:`OAU_SRC_LO];
  assign busy = (state_q != oau_pkg::ST_IDLE);
  assign ps_t = ps_q[`OAU_PS_T_BIT];
  assign mem_state = (state_q == oau_pkg::ST_FETCH) ||
    (state_q == oau_pkg::ST_NW) || (state_q == oau_pkg::ST_PTR) ||
    (state_q == oau_pkg::ST_OPND) || (state_q == oau_pkg::ST_RVAL) ||
    (state_q == oau_pkg::ST_VEC);
  assign word_acc = !((state_q == oau_pkg::ST_OPND) && ctrl_q[`OAU_CTRL_BYTE]);
  assign odd_fault = mem_state && word_acc && addr_q[0];
  assign mem_done = mem_state && MEM_ACK && !odd_fault;
  assign MEM_REQ = mem_state && !odd_fault;
  assign MEM_ADDR = {addr_q[15:1], 1'b0};
  assign wb_req = WB_CYC_I && WB_STB_I;
  assign wb_wr = wb_req && WB_WE_I && ack_q;
  assign sw_gpr = (WB_ADR_I[7:5] == `OAU_ADR_GPR_HI);

  oau_step #(.W(16)) u_step (
    .base(src_val),
    .byte_op(ctrl_q[`OAU_CTRL_BYTE]),
    .force_word(spec.mode[0] || (spec.rg >= `OAU_SP_IDX)),
    .down(spec.mode[2]),
    .result(stepped)
  );

  oau_step #(.W(16)) u_pcinc (
    .base(pc),
    .byte_op(1'b0),
    .force_word(1'b1),
    .down(1'b0),
    .result(pc_inc)
  );

  oau_gpr #(.W(16), .N(8)) u_gpr (
    .clk(CLOCK),
    .rst(SYS_RST),
    .we(gpr_we),
    .wa(gpr_wa),
    .wd(gpr_wd),
    .ra(spec.rg),
    .rb(instr_q[`OAU_DST_HI:`OAU_DST_LO]),
    .rc(WB_ADR_I[4:2]),
    .da(src_val),
    .db(dst_val),
    .dc(sw_val),
    .pc(pc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register side effects, one write per cycle
  always_comb begin
    gpr_we = 1'b0;
    gpr_wa = `OAU_PC_IDX;
    gpr_wd = pc_inc;
    unique case (state_q)
      oau_pkg::ST_FETCH, oau_pkg::ST_NW: begin
        gpr_we = mem_done;
      end
      oau_pkg::ST_DECODE: begin
        gpr_we = (spec.mode == `OAU_M_ADEC) ||
          (spec.mode == `OAU_M_ADECDEF);
        gpr_wa = spec.rg;
        gpr_wd = stepped;
      end
      oau_pkg::ST_OPND: begin
        gpr_we = mem_done && (spec.mode == `OAU_M_AINC);
        gpr_wa = spec.rg;
        gpr_wd = stepped;
      end
      oau_pkg::ST_PTR: begin
        gpr_we = mem_done && (spec.mode == `OAU_M_AINCDEF);
        gpr_wa = spec.rg;
        gpr_wd = stepped;
      end
      oau_pkg::ST_VEC: begin
        gpr_we = mem_done;
        gpr_wd = MEM_RDATA;
      end
      oau_pkg::ST_IDLE: begin
        gpr_we = wb_wr && sw_gpr && !ctrl_q[`OAU_CTRL_RUN];
        gpr_wa = WB_ADR_I[4:2];
        gpr_wd = WB_DAT_I[15:0];
      end
      default: begin
        gpr_we = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Interpretation sequencer
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= oau_pkg::ST_IDLE;
      instr_q <= 16'h0000;
      addr_q <= 16'h0000;
      sp_addr_q <= 16'h0000;
      opnd_q <= 16'h0000;
      reeval_q <= 16'h0000;
      vec_irq_q <= 1'b0;
    end else if (odd_fault) begin
      state_q <= oau_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        oau_pkg::ST_IDLE: begin
          if (ctrl_q[`OAU_CTRL_RUN] && IRQ_REQ) begin
            addr_q <= IRQ_VEC;
            vec_irq_q <= 1'b1;
            state_q <= oau_pkg::ST_VEC;
          end else if (ctrl_q[`OAU_CTRL_RUN]) begin
            addr_q <= pc;
            state_q <= oau_pkg::ST_FETCH;
          end
        end
        oau_pkg::ST_FETCH: begin
          if (mem_done) begin
            instr_q <= MEM_RDATA;
            state_q <= oau_pkg::ST_DECODE;
          end
        end
        oau_pkg::ST_DECODE: begin
          sp_addr_q <= spec.mode[2] ? stepped : src_val;
          unique case (spec.mode)
            `OAU_M_REG: begin
              opnd_q <= src_val;
              state_q <= oau_pkg::ST_CHECK;
            end
            `OAU_M_REGDEF, `OAU_M_AINC: begin
              addr_q <= src_val;
              state_q <= oau_pkg::ST_OPND;
            end
            `OAU_M_AINCDEF: begin
              addr_q <= src_val;
              state_q <= oau_pkg::ST_PTR;
            end
            `OAU_M_ADEC: begin
              addr_q <= stepped;
              state_q <= oau_pkg::ST_OPND;
            end
            `OAU_M_ADECDEF: begin
              addr_q <= stepped;
              state_q <= oau_pkg::ST_PTR;
            end
            `OAU_M_IDX, `OAU_M_IDXDEF: begin
              addr_q <= pc;
              state_q <= oau_pkg::ST_NW;
            end
          endcase
        end
        oau_pkg::ST_NW: begin
          if (mem_done) begin
            addr_q <= MEM_RDATA + ((spec.rg == `OAU_PC_IDX) ? pc_inc :
              src_val);
            state_q <= spec.mode[0] ? oau_pkg::ST_PTR : oau_pkg::ST_OPND;
          end
        end
        oau_pkg::ST_PTR: begin
          if (mem_done) begin
            addr_q <= MEM_RDATA;
            state_q <= oau_pkg::ST_OPND;
          end
        end
        oau_pkg::ST_OPND: begin
          if (mem_done) begin
            if (!ctrl_q[`OAU_CTRL_BYTE]) begin
              opnd_q <= MEM_RDATA;
            end else if (addr_q[0]) begin
              opnd_q <= {8'h00, MEM_RDATA[15:8]};
            end else begin
              opnd_q <= {8'h00, MEM_RDATA[7:0]};
            end
            state_q <= oau_pkg::ST_CHECK;
          end
        end
        oau_pkg::ST_CHECK: begin
          state_q <= oau_pkg::ST_EXEC;
          if (!ctrl_q[`OAU_CTRL_REEVAL]) begin
            state_q <= oau_pkg::ST_EXEC;
          end else if (spec.mode == `OAU_M_REG) begin
            reeval_q <= src_val;
          end else if (spec.mode == `OAU_M_REGDEF) begin
            addr_q <= src_val;
            state_q <= oau_pkg::ST_RVAL;
          end else if ((spec.mode == `OAU_M_AINC) &&
                       (spec.rg == `OAU_PC_IDX)) begin
            addr_q <= pc - `OAU_WORD_STEP;
            state_q <= oau_pkg::ST_RVAL;
          end
        end
        oau_pkg::ST_RVAL: begin
          if (mem_done) begin
            reeval_q <= MEM_RDATA;
            state_q <= oau_pkg::ST_EXEC;
          end
        end
        oau_pkg::ST_EXEC: begin
          if (ps_t) begin
            addr_q <= TRAP_VEC;
            vec_irq_q <= 1'b0;
            state_q <= oau_pkg::ST_VEC;
          end else begin
            state_q <= oau_pkg::ST_IDLE;
          end
        end
        oau_pkg::ST_VEC: begin
          if (mem_done) begin
            state_q <= oau_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result outputs
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      OPND_VALID <= 1'b0;
      OPND_DATA <= 16'h0000;
      DEST_DATA <= 16'h0000;
      IRQ_ACK <= 1'b0;
    end else begin
      OPND_VALID <= (state_q == oau_pkg::ST_EXEC);
      IRQ_ACK <= (state_q == oau_pkg::ST_VEC) && mem_done && vec_irq_q;
      if (state_q == oau_pkg::ST_EXEC) begin
        OPND_DATA <= opnd_q;
        DEST_DATA <= dst_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error and event flags: set wins over write-one-to-clear
  always_comb begin
    ev.bnd = odd_fault;
    ev.stk = (state_q == oau_pkg::ST_CHECK) && (spec.mode[2:1] != 2'h0) &&
      (spec.mode[2:1] != 2'h3) && (spec.rg == `OAU_SP_IDX) &&
      (sp_addr_q < `OAU_STACK_LIMIT);
    ev.trc = (state_q == oau_pkg::ST_EXEC) && ps_t;
    ev.irq = (state_q == oau_pkg::ST_IDLE) && ctrl_q[`OAU_CTRL_RUN] && IRQ_REQ;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      status_q <= `OAU_ST_RST;
    end else begin
      status_q <= (status_q & ~((wb_wr && WB_SEL_I[0] &&
        (WB_ADR_I == `OAU_ADR_STATUS)) ? WB_DAT_I[3:0] : 4'h0)) | ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: control, status, processor state and results
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_q <= `OAU_CTRL_RST;
      ps_q <= 16'h0000;
    end else begin
      if (wb_wr && WB_SEL_I[0] && (WB_ADR_I == `OAU_ADR_CTRL)) begin
        ctrl_q <= WB_DAT_I[2:0];
      end
      if (odd_fault) begin
        ctrl_q[`OAU_CTRL_RUN] <= 1'b0;
      end
      if (wb_wr && (WB_ADR_I == `OAU_ADR_PS)) begin
        if (WB_SEL_I[0]) ps_q[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) ps_q[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_q <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req && !ack_q;
      if (wb_req && !ack_q) begin
        WB_DAT_O <= 32'h0000_0000;
        if (sw_gpr) begin
          WB_DAT_O[15:0] <= sw_val;
        end else begin
          unique case (WB_ADR_I)
            `OAU_ADR_CTRL: WB_DAT_O[2:0] <= ctrl_q;
            `OAU_ADR_STATUS: WB_DAT_O <= {23'h0, busy, 4'h0, status_q};
            `OAU_ADR_PS: WB_DAT_O[15:0] <= ps_q;
            `OAU_ADR_INSTR: WB_DAT_O[15:0] <= instr_q;
            `OAU_ADR_OPND: WB_DAT_O[15:0] <= opnd_q;
            `OAU_ADR_DEST: WB_DAT_O[15:0] <= DEST_DATA;
            `OAU_ADR_REEVAL: WB_DAT_O[15:0] <= reeval_q;
            default: WB_DAT_O <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
  assign WB_ACK_O = ack_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  property p_fetch_pc;
    (state_q == oau_pkg::ST_FETCH) && mem_done |=>
      (pc == $past(pc) + 16'h0002) && (state_q == oau_pkg::ST_DECODE);
  endproperty
  a_fetch_pc: assert property (p_fetch_pc)
    else $error("PC not advanced by 2 after fetch");

  property p_mode0;
    (state_q == oau_pkg::ST_DECODE) && (spec.mode == `OAU_M_REG) |=>
      (opnd_q == $past(src_val)) && !MEM_REQ;
  endproperty
  a_mode0: assert property (p_mode0)
    else $error("Register mode operand wrong or memory used");

  property p_adec;
    (state_q == oau_pkg::ST_DECODE) && (spec.mode == `OAU_M_ADEC) |=>
      (addr_q == src_val) && (src_val != $past(src_val));
  endproperty
  a_adec: assert property (p_adec)
    else $error("Auto-decrement address is not the new register");

  property p_ainc;
    (state_q == oau_pkg::ST_OPND) && mem_done &&
      (spec.mode == `OAU_M_AINC) |=>
      (src_val == $past(stepped)) && ($past(addr_q) == $past(src_val));
  endproperty
  a_ainc: assert property (p_ainc)
    else $error("Auto-increment did not step after use");

  property p_pcrel;
    (state_q == oau_pkg::ST_NW) && mem_done && (spec.rg == `OAU_PC_IDX) |=>
      addr_q == $past(MEM_RDATA) + pc;
  endproperty
  a_pcrel: assert property (p_pcrel)
    else $error("PC-relative address not against updated PC");

  property p_ptr;
    (state_q == oau_pkg::ST_PTR) && mem_done |=>
      (addr_q == $past(MEM_RDATA)) && (state_q == oau_pkg::ST_OPND) &&
      (MEM_REQ != odd_fault);
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("Operand not read through pointer");

  property p_stack;
    ev.stk |=> status_q[`OAU_ST_STK] && (state_q == oau_pkg::ST_EXEC);
  endproperty
  a_stack: assert property (p_stack)
    else $error("Stack overflow not flagged");

  property p_bound;
    odd_fault |=> !ctrl_q[`OAU_CTRL_RUN] && status_q[`OAU_ST_BND] &&
      (state_q == oau_pkg::ST_IDLE);
  endproperty
  a_bound: assert property (p_bound)
    else $error("Odd word access not trapped");

  property p_reeval;
    (state_q == oau_pkg::ST_CHECK) && ctrl_q[`OAU_CTRL_REEVAL] &&
      (spec.mode == `OAU_M_AINC) && (spec.rg == `OAU_PC_IDX) |=>
      MEM_REQ && (MEM_ADDR == pc - 16'h0002) && (pc == $past(pc));
  endproperty
  a_reeval: assert property (p_reeval)
    else $error("Re-evaluation did not read at PC minus 2");

  property p_irq;
    ev.irq |=> (state_q == oau_pkg::ST_VEC) && (MEM_ADDR == IRQ_VEC);
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt not taken ahead of fetch");

  property p_trace;
    (state_q == oau_pkg::ST_EXEC) && ps_t |=> OPND_VALID &&
      (state_q == oau_pkg::ST_VEC) && (MEM_ADDR == TRAP_VEC);
  endproperty
  a_trace: assert property (p_trace)
    else $error("Trace trap missing after instruction");

  property p_cov_idxdef;
    (state_q == oau_pkg::ST_PTR) && (spec.mode == `OAU_M_IDXDEF) && mem_done;
  endproperty
  c_idxdef: cover property (p_cov_idxdef);
  c_irq: cover property (IRQ_ACK);
  c_trace: cover property (ev.trc);
  c_stack: cover property (ev.stk);
endmodule
`default_nettype wire

// ==== verification/oau_mem_model.sv ====
// Primary memory model: word reads answered after a varying wait
`default_nettype none
module oau_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [15:0] addr,
  input wire logic [2:0] wait_cycles,
  output logic ack,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [1024];
  logic [2:0] cnt;
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = (16'(i) * 16'h0006 + 16'h0100) & 16'h07fe;
    end
  end
  // Data lines change every cycle outside the answer cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      cnt <= 3'h0;
      rdata <= 16'h0;
    end else if (req && !ack && cnt == wait_cycles) begin
      ack <= 1'b1;
      cnt <= 3'h0;
      rdata <= mem[addr[10:1]];
    end else begin
      ack <= 1'b0;
      cnt <= (req && !ack) ? cnt + 3'h1 : 3'h0;
      rdata <= ~rdata;
    end
  end
endmodule
`default_nettype wire

// ==== verification/oau_top_tb_top.sv ====
// Self-checking bench for the operand address unit
`default_nettype none
module oau_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cyc, stb, we, wack, mreq, mack, irq_req, irq_ack;
  logic ovalid, seen;
  logic [7:0] adr;
  logic [31:0] wdat, wout, seed, rnd, q;
  logic [15:0] maddr, mrdata, odata, ddata, reeval_exp, first_addr;
  logic [2:0] mwait;
  logic [15:0] r [8];
  logic [31:0] exp_q [$];
  int fail_count, cmp_count, irq_cnt;
  // Source mode, source register, destination register
  localparam logic [8:0] PROG [16] = '{9'h008, 9'h052, 9'h080, 9'h11b,
    9'h189, 9'h1bc, 9'h0d2, 9'h0fd, 9'h164, 9'h1c1, 9'h1fe, 9'h136,
    9'h137, 9'h0b8, 9'h0c3, 9'h068};

  oau_top dut (.CLOCK(clk), .SYS_RST(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(wdat), .WB_DAT_O(wout), .WB_ACK_O(wack), .MEM_REQ(mreq),
    .MEM_ADDR(maddr), .MEM_ACK(mack), .MEM_RDATA(mrdata),
    .IRQ_REQ(irq_req), .IRQ_ACK(irq_ack), .OPND_VALID(ovalid),
    .OPND_DATA(odata), .DEST_DATA(ddata));
  oau_mem_model mem_i (.clk(clk), .rst(rst), .req(mreq), .addr(maddr),
    .wait_cycles(mwait), .ack(mack), .rdata(mrdata));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] mem_word(input logic [15:0] a);
    return mem_i.mem[a[10:1]];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      fail_count++;
      $display("mismatch at %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wack !== 1'b1 && n < 64);
    if (n >= 64) begin
      fail_count++;
      test_done();
    end
    q = wout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Reference operand fetch with register side effects
  task automatic oprd(input logic [2:0] m, g, output logic [15:0] v);
    logic [15:0] t;
    t = 16'h0;
    if (m == 3'h4 || m == 3'h5) r[g] = r[g] - 16'h0002;
    if (m >= 3'h6) begin
      t = mem_word(r[7]);
      r[7] = r[7] + 16'h0002;
    end
    case (m)
      3'h0: v = r[g];
      3'h1, 3'h4: v = mem_word(r[g]);
      3'h2: begin
        v = mem_word(r[g]);
        r[g] = r[g] + 16'h0002;
      end
      3'h3: begin
        v = mem_word(mem_word(r[g]));
        r[g] = r[g] + 16'h0002;
      end
      3'h5: v = mem_word(mem_word(r[g]));
      3'h6: v = mem_word(t + r[g]);
      default: v = mem_word(mem_word(t + r[g]));
    endcase
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    seed <= lfsr(seed);
    mwait <= seed[2:0];
    // Requester drops its line as the vector read is answered
    if (mreq === 1'b1 && mack === 1'b1 && maddr == 16'h0020) begin
      irq_req <= 1'b0;
    end
  end
  always @(negedge clk) begin
    if (mreq === 1'b1 && !seen) begin
      seen = 1'b1;
      first_addr = maddr;
    end
    if (irq_ack === 1'b1) irq_cnt++;
    if (ovalid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk({odata, ddata}, exp_q.pop_front());
    end
  end
  initial begin
    #1200000;
    fail_count++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] p, v;
    int i;
    rst = 1'b1;
    {cyc, stb, we, irq_req, seen} = 5'h0;
    adr = 8'h0;
    wdat = 32'h0;
    seed = 32'hc497e604;
    rnd = seed;
    mwait = 3'h0;
    {fail_count, cmp_count, irq_cnt} = {32'h0, 32'h0, 32'h0};
    first_addr = 16'h0;
    reeval_exp = 16'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(8'h00, 1'b0, 32'h0);
    chk(q, 32'h0);
    wb(8'h04, 1'b0, 32'h0);
    chk(q, 32'h0);
    wb(8'hfc, 1'b1, 32'hffff);
    wb(8'hfc, 1'b0, 32'h0);
    chk(q, 32'h0);
    mem_i.mem[16] = 16'h0600;
    p = 16'h0600;
    for (i = 0; i < 16; i++) begin
      mem_i.mem[p[10:1]] = {4'h1, PROG[i][8:3], 3'h0, PROG[i][2:0]};
      p = p + 16'h0002;
      if (PROG[i][8:7] == 2'h3 || PROG[i][8:3] == 6'h1f ||
          PROG[i][8:3] == 6'h17) begin
        rnd = lfsr(rnd);
        mem_i.mem[p[10:1]] = rnd[15:0] & 16'h07fe;
        p = p + 16'h0002;
      end
    end
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      r[i] = (i == 5) ? 16'h0001 : (i == 6) ? 16'h0102 :
        (i == 7) ? 16'h0000 : rnd[15:0] & 16'h07fe;
      wb(8'(32'h20 + 4 * i), 1'b1, {16'h0, r[i]});
    end
    wb(8'h24, 1'b0, 32'h0);
    chk(q, {16'h0, r[1]});
    r[7] = 16'h0600;
    for (i = 0; i < 15; i++) begin
      r[7] = r[7] + 16'h0002;
      oprd(PROG[i][8:6], PROG[i][5:3], v);
      if (PROG[i][8:3] == 6'h17) reeval_exp = v;
      exp_q.push_back({v, r[PROG[i][2:0]]});
    end
    $display("register test done");
    irq_req <= 1'b1;
    wb(8'h00, 1'b1, 32'h5);
    i = 0;
    do begin
      wb(8'h00, 1'b0, 32'h0);
      i++;
    end while (q[0] !== 1'b0 && i < 2000);
    chk(q, 32'h4);
    chk({16'h0, first_addr}, 32'h20);
    chk(32'(irq_cnt), 32'h1);
    chk(32'(exp_q.size()), 32'h0);
    wb(8'h04, 1'b0, 32'h0);
    chk(q, 32'hb);
    wb(8'h18, 1'b0, 32'h0);
    chk(q, {16'h0, reeval_exp});
    for (i = 0; i < 7; i++) begin
      wb(8'(32'h20 + 4 * i), 1'b0, 32'h0);
      chk(q, {16'h0, r[i]});
    end
    $display("operand test done");
    test_done();
  end
endmodule
`default_nettype wire
